//--- core/kcp_pkg.sv
/*
 * kcp_pkg: register addresses, field positions, reset values and encodings
 * for the key-switch monitor configuration and port register bank.
 * Assumes an 8-bit register address and 8-bit data from the serial bus front end.
 */
package kcp_pkg;
  localparam logic [7:0] ADDR_INTR   = 8'h03;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_PORTS  = 8'h05;
  localparam logic [7:0] ADDR_KSND   = 8'h06;
  localparam logic [7:0] ADDR_ASND   = 8'h07;

  localparam logic [7:0] CONFIG_RST  = 8'h01;
  localparam logic [7:0] PORTS_RST   = 8'hFE;
  localparam logic [7:0] KSND_RST    = 8'h51;
  localparam logic [7:0] ASND_RST    = 8'hBB;
  localparam logic [4:0] INTR_PERIOD_RST = 5'h00;

  // configuration fields
  localparam int CFG_TMO_DIS   = 0;
  localparam int CFG_SRC_LO    = 1;
  localparam int CFG_ALT_NOW   = 3;
  localparam int CFG_ALT_IEN   = 4;
  localparam int CFG_ALT_SND   = 5;
  localparam int CFG_KEY_SND   = 6;
  localparam int CFG_RUN       = 7;

  // ports fields
  localparam int PRT_ALERT     = 0;
  localparam int PRT_INTPORT   = 1;
  localparam int PRT_FIRST     = 2;
  localparam int PRT_LAST      = 7;

  // interrupt register fields
  localparam int INT_KEY_EV    = 5;
  localparam int INT_ALT_EV    = 6;
  localparam int INT_ANY       = 7;

  // sounder source codes
  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_HOST  = 2'h1,
    SRC_KEY   = 2'h2,
    SRC_ALERT = 2'h3
  } kcp_src_t;
endpackage : kcp_pkg

//--- core/kcp_sync_if.sv
/*
 * kcp_sync_if: carries the synchronised alert level and its falling-edge pulse
 * from the input conditioner to the register bank. Single clock domain.
 */
`timescale 1ns/1ps
interface kcp_sync_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input  level, input  fall);
endinterface : kcp_sync_if

//--- core/kcp_alert_sync.sv
/*
 * kcp_alert_sync: two-flop synchroniser and falling-edge detector for the
 * alert pin. Assumes the pin is asynchronous to ref_clk_in.
 */
`timescale 1ns/1ps
module kcp_alert_sync (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic alert_pin_in,
  kcp_sync_if.src   sync
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;

  // sh_q[0] feeds only sh_q[1]; edge logic looks at stages 1 and 2
  always_comb begin
    sh_d = {sh_q[1:0], alert_pin_in};
  end

  // reset high, so a pin low at power-up gives one fall pulse two cycles after reset
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sh_q <= 3'h7;
    end else begin
      sh_q <= sh_d;
    end
  end

  assign sync.level = sh_q[1];
  assign sync.fall  = sh_q[2] & ~sh_q[1];
endmodule : kcp_alert_sync

//--- core/kcp_regs.sv
/*
 * kcp_regs: configuration, ports, interrupt and sound registers of a key-switch
 * monitor, with the open-drain port outputs and the interrupt pin.
 * Assumes a serial bus front end that gives single-cycle write and read strobes
 * with an 8-bit address, and a key engine that reports debounce cycles, new keys,
 * queue empty and sounder activity on the same clock.
 */
// Contract
// - interrupt status bits ignore host writes
// - interrupt read clears alert, keeps key-scan
// - key-scan interrupt ends when queue empties
// - config bit 0 low enables bus timeout
// - config bits 2:1 report sounder source
// - config bit 3 makes alert interrupt immediate
// - config bit 4 enables alert falling-edge interrupt
// - config bit 5 sends alert sound on edge
// - config bit 6 sends key sound per key
// - shutdown stops scanning, sounder, interrupts; ports live
// - operating mode runs scanning and sounder queue
// - port bits written 0 drive low, 1 release
// - ports bit 0 reads alert pin level
// - zero period frees interrupt pin as port
// - period N asserts pending key interrupt every N debounce cycles
`timescale 1ns/1ps
module kcp_regs (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // register access from the serial front end
  input  wire logic       wr_stb_in,
  input  wire logic       rd_stb_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  // key engine status
  input  wire logic       debounce_tick_in,
  input  wire logic       new_key_in,
  input  wire logic       queue_empty_in,
  input  wire logic       snd_active_in,
  input  wire logic       snd_host_in,
  // pins
  input  wire logic       alert_pin_in,
  output logic      [5:0] port_out,
  output logic      [5:0] port_oe_out,
  output logic            int_pin_out,
  output logic            int_pin_oe_out,
  // controls towards the rest of the device
  output logic            bus_timeout_en_out,
  output logic            run_out,
  output logic            snd_req_out,
  output logic      [7:0] snd_cmd_out
);
  kcp_sync_if alert_if ();

  kcp_alert_sync u_alert_sync (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .alert_pin_in (alert_pin_in),
    .sync         (alert_if.src)
  );

  logic [7:0] cfg_q, cfg_d;
  logic [7:0] prt_q, prt_d;
  logic [4:0] per_q, per_d;
  logic [7:0] ksnd_q, ksnd_d;
  logic [7:0] asnd_q, asnd_d;
  logic       key_ev_q, key_ev_d;
  logic       alt_ev_q, alt_ev_d;
  logic       alt_pend_q, alt_pend_d;
  logic       key_pend_q, key_pend_d;
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] src_q, src_d;
  logic       sreq_q, sreq_d;
  logic [7:0] scmd_q, scmd_d;
  logic [7:0] rdata_q, rdata_d;

  logic       running;
  logic       period_end;
  logic [4:0] eff_per;

  // sound command: bit 0 forced to 1, continuous duration becomes 1000 ms code
  function automatic logic [7:0] snd_fix(input logic [7:0] v);
    snd_fix = (v[7:5] == 3'h0) ? {3'h7, v[4:1], 1'b1} : {v[7:1], 1'b1};
  endfunction : snd_fix

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  assign running = cfg_q[kcp_pkg::CFG_RUN];
  // zero period still runs status as if period were one
  assign eff_per    = (per_q == 5'h00) ? 5'h01 : per_q;
  assign period_end = running & debounce_tick_in & (cnt_q + 5'h01 >= eff_per);

  // register writes and status bookkeeping
  always_comb begin
    cfg_d      = cfg_q;
    prt_d      = prt_q;
    per_d      = per_q;
    ksnd_d     = ksnd_q;
    asnd_d     = asnd_q;
    key_ev_d   = key_ev_q;
    alt_ev_d   = alt_ev_q;
    alt_pend_d = alt_pend_q;
    key_pend_d = key_pend_q;
    cnt_d      = cnt_q;
    sreq_d     = 1'b0;
    scmd_d     = scmd_q;
    src_d      = src_q;
    if (wr_stb_in) begin
      unique case (addr_in)
        kcp_pkg::ADDR_INTR:   per_d = wdata_in[4:0];
        // sounder source bits are status, not writable
        kcp_pkg::ADDR_CONFIG: cfg_d = {wdata_in[7:3], cfg_q[2:1], wdata_in[0]};
        kcp_pkg::ADDR_PORTS:  prt_d = {wdata_in[7:1], 1'b0};
        kcp_pkg::ADDR_KSND:   ksnd_d = wdata_in;
        kcp_pkg::ADDR_ASND:   asnd_d = wdata_in;
        default: ;
      endcase
    end
    // debounce period counter and deferred events
    if (running && debounce_tick_in) begin
      cnt_d = period_end ? 5'h00 : cnt_q + 5'h01;
      if (new_key_in) key_pend_d = 1'b1;
    end
    if (!running) cnt_d = 5'h00;
    // reading the interrupt register clears only the alert event
    if (rd_stb_in && hit(addr_in, kcp_pkg::ADDR_INTR)) alt_ev_d = 1'b0;
    // key-scan event lasts until the queue is drained
    if (queue_empty_in) key_ev_d = 1'b0;
    if (period_end) begin
      if (key_pend_q || (new_key_in && debounce_tick_in)) key_ev_d = 1'b1;
      if (alt_pend_q) alt_ev_d = 1'b1;
      key_pend_d = 1'b0;
      alt_pend_d = 1'b0;
    end
    // alert edge: set wins over the read clear
    if (running && alert_if.fall && cfg_q[kcp_pkg::CFG_ALT_IEN]) begin
      if (cfg_q[kcp_pkg::CFG_ALT_NOW]) alt_ev_d = 1'b1;
      else alt_pend_d = 1'b1;
    end
    // sounder requests; key sound takes priority when both arrive together
    if (running && alert_if.fall && cfg_q[kcp_pkg::CFG_ALT_SND]) begin
      sreq_d = 1'b1;
      scmd_d = snd_fix(asnd_q);
      src_d  = kcp_pkg::SRC_ALERT;
    end
    if (running && new_key_in && debounce_tick_in && cfg_q[kcp_pkg::CFG_KEY_SND]) begin
      sreq_d = 1'b1;
      scmd_d = snd_fix(ksnd_q);
      src_d  = kcp_pkg::SRC_KEY;
    end
    if (snd_host_in) src_d = kcp_pkg::SRC_HOST;
    if (!snd_active_in && !sreq_d && !snd_host_in) src_d = kcp_pkg::SRC_NONE;
    cfg_d[2:1] = src_d;
    // shutdown drops all interrupt state
    if (!running) begin
      key_ev_d   = 1'b0;
      alt_ev_d   = 1'b0;
      alt_pend_d = 1'b0;
      key_pend_d = 1'b0;
      sreq_d     = 1'b0;
    end
  end

  // read data, registered one cycle after the read strobe
  always_comb begin
    rdata_d = 8'h00;
    unique case (addr_in)
      kcp_pkg::ADDR_INTR:   rdata_d = {key_ev_q | alt_ev_q, alt_ev_q, key_ev_q, per_q};
      kcp_pkg::ADDR_CONFIG: rdata_d = cfg_q;
      kcp_pkg::ADDR_PORTS:  rdata_d = {prt_q[7:1], alert_if.level};
      kcp_pkg::ADDR_KSND:   rdata_d = {ksnd_q[7:1], 1'b1};
      kcp_pkg::ADDR_ASND:   rdata_d = {asnd_q[7:1], 1'b1};
      default:              rdata_d = 8'h00;
    endcase
    if (!rd_stb_in) rdata_d = rdata_q;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q      <= kcp_pkg::CONFIG_RST;
      prt_q      <= kcp_pkg::PORTS_RST;
      per_q      <= kcp_pkg::INTR_PERIOD_RST;
      ksnd_q     <= kcp_pkg::KSND_RST;
      asnd_q     <= kcp_pkg::ASND_RST;
      key_ev_q   <= 1'b0;
      alt_ev_q   <= 1'b0;
      alt_pend_q <= 1'b0;
      key_pend_q <= 1'b0;
      cnt_q      <= 5'h00;
      src_q      <= kcp_pkg::SRC_NONE;
      sreq_q     <= 1'b0;
      scmd_q     <= 8'h00;
      rdata_q    <= 8'h00;
    end else begin
      cfg_q      <= cfg_d;
      prt_q      <= prt_d;
      per_q      <= per_d;
      ksnd_q     <= ksnd_d;
      asnd_q     <= asnd_d;
      key_ev_q   <= key_ev_d;
      alt_ev_q   <= alt_ev_d;
      alt_pend_q <= alt_pend_d;
      key_pend_q <= key_pend_d;
      cnt_q      <= cnt_d;
      src_q      <= src_d;
      sreq_q     <= sreq_d;
      scmd_q     <= scmd_d;
      rdata_q    <= rdata_d;
    end
  end

  // open drain: outputs always low, enable when bit is 0
  assign port_out    = 6'h00;
  assign port_oe_out = ~prt_q[kcp_pkg::PRT_LAST:kcp_pkg::PRT_FIRST];
  assign int_pin_out = 1'b0;
  // zero period hands the pin over to the ports register
  assign int_pin_oe_out = (per_q == 5'h00) ? ~prt_q[kcp_pkg::PRT_INTPORT]
                                           : (key_ev_q | alt_ev_q);
  assign rdata_out          = rdata_q;
  assign bus_timeout_en_out = ~cfg_q[kcp_pkg::CFG_TMO_DIS];
  assign run_out            = running;
  assign snd_req_out        = sreq_q;
  assign snd_cmd_out        = scmd_q;
endmodule : kcp_regs

//--- test/kcp_regs_props.sv
/* kcp_regs_props: port-level checks of the config and port registers and of the sound request.
   Assumes one clock and a bind onto kcp_regs. */
`timescale 1ns/1ps
module kcp_regs_props (
  input wire logic       ref_clk_in, nrst_in, wr_stb_in, rd_stb_in, alert_pin_in,
  input wire logic [7:0] addr_in, wdata_in, rdata_out, snd_cmd_out,
  input wire logic [5:0] port_out, port_oe_out,
  input wire logic       bus_timeout_en_out, run_out, snd_req_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // decoded accesses, shared by several checks
  logic wcfg, wprt, rprt;
  assign wcfg = wr_stb_in && addr_in == 8'h04;
  assign wprt = wr_stb_in && addr_in == 8'h05;
  assign rprt = rd_stb_in && addr_in == 8'h05;

  chk_timeout_bit: assert property (
    wcfg |=> bus_timeout_en_out == !$past(wdata_in[0])) else $error("timeout enable wrong");
  chk_run_bit: assert property (
    wcfg |=> run_out == $past(wdata_in[7])) else $error("run mode wrong");
  chk_port_drive: assert property (
    wprt |=> port_oe_out == ~$past(wdata_in[7:2])) else $error("port drive wrong");
  chk_port_level: assert property (
    port_out == 6'h00) else $error("open drain data not low");
  chk_port_readback: assert property (
    rprt |=> rdata_out[7:2] == ~$past(port_oe_out)) else $error("port readback wrong");
  // alert level must have settled through the synchroniser first
  chk_alert_read: assert property (
    $stable(alert_pin_in) [*4] ##0 rprt |=> rdata_out[0] == $past(alert_pin_in))
    else $error("alert level readback wrong");
  chk_quiet_shutdown: assert property (
    !run_out && !$past(run_out) |-> !snd_req_out) else $error("sound in shutdown");
  chk_snd_cmd_form: assert property (
    snd_req_out |-> snd_cmd_out[0] && snd_cmd_out[7:5] != 3'h0) else $error("bad sound cmd");
endmodule : kcp_regs_props

bind kcp_regs kcp_regs_props kcp_regs_props_i (.ref_clk_in, .nrst_in, .wr_stb_in,
  .rd_stb_in, .alert_pin_in, .addr_in, .wdata_in, .rdata_out, .snd_cmd_out, .port_out,
  .port_oe_out, .bus_timeout_en_out, .run_out, .snd_req_out);

//--- test/kcp_host_model.sv
/* kcp_host_model: host side of register access, one byte per strobe.
   Assumes the falling clock edge is free for driving. */
`timescale 1ns/1ps
module kcp_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_stb_out,
  output logic            rd_stb_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out
);
  // idle bus; released lines show the inverse so stale values never pass
  initial begin
    wr_stb_out = 1'b0;
    rd_stb_out = 1'b0;
    addr_out = 8'hFF;
    wdata_out = 8'h00;
  end
  // strobe held across exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    wr_stb_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge ref_clk_in);
    wr_stb_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    rd_stb_out = 1'b1;
    addr_out = a;
    @(negedge ref_clk_in);
    rd_stb_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd
endmodule : kcp_host_model

//--- test/kcp_regs_tb.sv
/* kcp_regs_tb: register and pin checks driven through the host model.
   Assumes the key engine and sounder status come from here, host sound idle. */
`timescale 1ns/1ps
module kcp_regs_tb;
  logic       ref_clk_in, nrst_in, wr_stb_in, rd_stb_in, debounce_tick_in, new_key_in;
  logic       queue_empty_in, snd_active_in, snd_host_in, alert_pin_in, int_pin_out;
  logic       int_pin_oe_out, bus_timeout_en_out, run_out, snd_req_out;
  logic [7:0] addr_in, wdata_in, rdata_out, snd_cmd_out, d, cmd;
  logic [5:0] port_out, port_oe_out;
  int         error_cnt = 0, tests_run = 0, snd_n = 0;

  kcp_regs kcp_regs_i (.ref_clk_in, .nrst_in, .wr_stb_in, .rd_stb_in, .addr_in,
    .wdata_in, .rdata_out, .debounce_tick_in, .new_key_in, .queue_empty_in,
    .snd_active_in, .snd_host_in, .alert_pin_in, .port_out, .port_oe_out, .int_pin_out,
    .int_pin_oe_out, .bus_timeout_en_out, .run_out, .snd_req_out, .snd_cmd_out);
  kcp_host_model host_i (.ref_clk_in, .rdata_in(rdata_out), .wr_stb_out(wr_stb_in),
    .rd_stb_out(rd_stb_in), .addr_out(addr_in), .wdata_out(wdata_in));

  // 250 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // count sounder requests away from the launching edge
  always @(negedge ref_clk_in) begin
    if (snd_req_out === 1'b1) begin
      snd_n++;
      cmd = snd_cmd_out;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic c1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : c1
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host_i.rd(a, d);
    chk(d, exp);
  endtask : rdc
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : w
  // one debounce cycle end with a new key
  task automatic tk;
    @(negedge ref_clk_in);
    debounce_tick_in = 1'b1;
    new_key_in = 1'b1;
    @(negedge ref_clk_in);
    debounce_tick_in = 1'b0;
    new_key_in = 1'b0;
  endtask : tk
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // a hang costs far more than the roughly 60 cycles of the sequence
  initial begin
    #8000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    nrst_in = 1'b0;
    {debounce_tick_in, new_key_in, snd_active_in, snd_host_in} = 4'h0;
    queue_empty_in = 1'b1;
    alert_pin_in = 1'b1;
    w(4);
    nrst_in = 1'b1;
    rdc(8'h04, 8'h01);
    c1(bus_timeout_en_out, 1'b0);
    rdc(8'h05, 8'hFF);
    // shutdown: ports and interrupt port stay usable
    host_i.wr(8'h05, 8'h00);
    chk({2'h0, port_oe_out}, 8'h3F);
    c1(int_pin_oe_out, 1'b1);
    alert_pin_in = 1'b0;
    w(5);
    rdc(8'h05, 8'h00);
    host_i.wr(8'h05, 8'hA9);
    chk({2'h0, port_oe_out}, 8'h15);
    rdc(8'h05, 8'hA8);
    host_i.wr(8'h05, 8'hFE);
    c1(int_pin_oe_out, 1'b0);
    alert_pin_in = 1'b1;
    host_i.wr(8'h03, 8'hE1);
    rdc(8'h03, 8'h01);
    host_i.wr(8'h04, 8'hFE);
    rdc(8'h04, 8'hF8);
    c1(bus_timeout_en_out, 1'b1);
    // alert edge: immediate interrupt and alert sound; sounder kept busy
    snd_active_in = 1'b1;
    alert_pin_in = 1'b0;
    w(6);
    c1(int_pin_oe_out, 1'b1);
    chk(cmd, 8'hBB);
    rdc(8'h04, 8'hFE);
    rdc(8'h03, 8'hC1);
    rdc(8'h03, 8'h01);
    c1(int_pin_oe_out, 1'b0);
    // key event: survives reads until the queue drains
    queue_empty_in = 1'b0;
    tk();
    w(2);
    c1(int_pin_oe_out, 1'b1);
    chk(cmd, 8'h51);
    rdc(8'h04, 8'hFC);
    rdc(8'h03, 8'hA1);
    rdc(8'h03, 8'hA1);
    queue_empty_in = 1'b1;
    snd_active_in = 1'b0;
    w(2);
    c1(int_pin_oe_out, 1'b0);
    // shutdown again: keys make neither sound nor interrupt
    host_i.wr(8'h04, 8'h61);
    queue_empty_in = 1'b0;
    tk();
    w(3);
    chk(8'(snd_n), 8'h02);
    c1(int_pin_oe_out, 1'b0);
    final_report();
  end
endmodule : kcp_regs_tb
